// ==== hdl/arc_io.sv ====
`timescale 1ns/100ps
`default_nettype none
module arc_io
  import arc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire arc_in_t     i_inputs,
  input  wire arc_obj_t    i_object,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_open_request,
  output logic             o_close_request,
  output logic [4:0]       o_request_on,
  output logic             o_ready,
  output logic             o_running,
  output logic             o_dead_time,
  output logic             o_reclaim_time,
  output logic             o_locked,
  output logic             o_recloser_on,
  output logic             o_irq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam int EQ = 4;
  typedef struct packed {
    arc_in_t              s1;
    arc_in_t              s2;
    arc_in_t              prev;
    arc_state_t           st;
    logic [4:0]           cause;
    logic                 lock_after;
    logic [31:0]          ctrl;
    logic [31:0]          evt_en;
    logic [IRQ_BITS-1:0]  irq_st;
    logic [IRQ_BITS-1:0]  irq_msk;
    logic [NUM_CNT-1:0][31:0] cnt;
    logic [31:0]          tick_cnt;
    logic [31:0]          ms;
    logic [NUM_EVT_SRC-1:0] prev_src;
    arc_event_t [EQ-1:0]  evq;
    logic [2:0]           evn;
    logic [31:0]          rdata;
    logic                 ack;
  } arc_reg_t;
  arc_reg_t q;
  arc_reg_t d;

  logic                   en_eff;
  logic [4:0]             winner;
  logic [NUM_EVT_SRC-1:0] src;
  logic [NUM_EVT_SRC-1:0] chg;
  logic                   wr;
  logic                   rd;
  logic [IRQ_BITS-1:0]    irq_set;
  logic                   in_seq;
  int                     k;

  always_comb begin
    d        = q;
    irq_set  = '0;
    d.s1     = i_inputs;
    d.s2     = q.s1;
    d.prev   = q.s2;
    d.ack    = 1'b0;
    wr       = i_avs_write && q.ack;
    rd       = i_avs_read && !q.ack;
    en_eff = q.ctrl[CTRL_ENABLE] &&
             (!q.ctrl[CTRL_SELECT] || q.s2.recloser_enable_input);
    // Fixed priority pick, lowest index wins
    winner = '0;
    for (int i = 4; i >= 0; i--) begin
      if (q.s2.reclose_request[i]) begin
        winner = 5'h01 << i;
      end
    end
    in_seq = (q.st != ST_READY) && (q.st != ST_LOCKED);
    // ----------------------------------------------------------
    // Millisecond timebase
    // ----------------------------------------------------------
    if (q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      d.tick_cnt = '0;
      d.ms       = q.ms + 32'h1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h1;
    end
    // ----------------------------------------------------------
    // Sequence control
    // ----------------------------------------------------------
    if (q.s2.immediate_lock_request && !q.prev.immediate_lock_request) begin
      d.st = ST_LOCKED;
      d.cause = '0;
      irq_set[IRQ_LOCK] = 1'b1;
      d.cnt[CNT_CRIT] = q.cnt[CNT_CRIT] + 32'h1;
    end else if (q.s2.lock_force_input) begin
      d.st = ST_LOCKED;
      d.cause = '0;
    end else if (i_object.check_failed && in_seq) begin
      d.st = ST_LOCKED;
      d.cause = '0;
      irq_set[IRQ_FAIL] = 1'b1;
    end else if (q.st == ST_DEAD && i_object.manual_close && q.s2.fault_present) begin
      d.st = ST_RECLAIM;
      d.lock_after = 1'b1;
      d.cause = '0;
    end else if (in_seq && (i_object.manual_open || i_object.manual_close)) begin
      d.st = ST_READY;
      d.cause = '0;
    end else begin
      case (q.st)
        ST_READY: begin
          if (en_eff && winner != 5'h00) begin
            d.st = ST_OPENING;
            d.cause = winner;
            for (int i = 0; i < 5; i++) begin
              if (winner[i]) begin
                d.cnt[i] = q.cnt[i] + 32'h1;
              end
            end
            d.cnt[CNT_SHOT] = q.cnt[CNT_SHOT] + 32'h1;
            irq_set[IRQ_SHOT] = 1'b1;
          end
        end
        ST_OPENING: begin
          if (i_object.open_done) begin
            d.st = ST_DEAD;
          end
        end
        ST_DEAD: begin
          if (i_object.dead_expired) begin
            d.st = ST_CLOSING;
          end
        end
        ST_CLOSING: begin
          if (i_object.close_done) begin
            d.st = ST_RECLAIM;
          end
        end
        ST_RECLAIM: begin
          if (i_object.reclaim_expired) begin
            d.st = q.lock_after ? ST_LOCKED : ST_READY;
            d.lock_after = 1'b0;
            d.cause = '0;
          end
        end
        ST_LOCKED: begin
          if (q.s2.lock_release_input || q.ctrl[CTRL_REL]) begin
            d.st = ST_READY;
          end
        end
        default: begin
          d.st = ST_LOCKED;
        end
      endcase
    end
    // ----------------------------------------------------------
    // Event log
    // ----------------------------------------------------------
    src = {q.s2, (q.st == ST_OPENING), (q.st == ST_CLOSING),
           (q.st == ST_LOCKED), (q.st != ST_READY)};
    chg = (src ^ q.prev_src) & q.evt_en[NUM_EVT_SRC-1:0];
    d.prev_src = src;
    k = 0;
    for (int i = 0; i < NUM_EVT_SRC; i++) begin
      if (chg[i] && (32'(q.evn) + 32'(k)) < EQ) begin
        d.evq[3'(32'(q.evn) + 32'(k))] = '{stamp: q.ms, source: 4'(i),
                                           level: src[i]};
        k = k + 1;
      end
    end
    d.evn = 3'(32'(q.evn) + 32'(k));
    if (chg != '0) begin
      irq_set[IRQ_EVENT] = 1'b1;
    end
    // ----------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------
    d.ctrl[CTRL_REL] = 1'b0;
    // Writes land at the edge where waitrequest is seen low
    if ((i_avs_write || i_avs_read) && !q.ack) begin
      d.ack = 1'b1;
    end
    if (wr) begin
      case (i_avs_address)
        ADDR_CTRL:    d.ctrl = i_avs_writedata & 32'h0000_0007;
        ADDR_EVT_EN:  d.evt_en = i_avs_writedata & EVT_EN_RESET;
        ADDR_IRQ_ST:  d.irq_st = q.irq_st & ~i_avs_writedata[IRQ_BITS-1:0];
        ADDR_IRQ_MSK: d.irq_msk = i_avs_writedata[IRQ_BITS-1:0];
        ADDR_CNT_CLR: begin
          for (int i = 0; i < NUM_CNT; i++) begin
            if (i_avs_writedata[i]) begin
              d.cnt[i] = '0;
            end
          end
        end
        default: ;
      endcase
    end
    d.irq_st = d.irq_st | irq_set;
    if (rd) begin
      d.rdata = '0;
      case (i_avs_address)
        ADDR_CTRL:    d.rdata = q.ctrl;
        ADDR_STATUS:  d.rdata = {21'h0, en_eff, q.cause, q.lock_after, 1'b0, q.st};
        ADDR_EVT_EN:  d.rdata = q.evt_en;
        ADDR_IRQ_ST:  d.rdata = 32'(q.irq_st);
        ADDR_IRQ_MSK: d.rdata = 32'(q.irq_msk);
        ADDR_EVT_POP: begin
          if (q.evn != 3'h0) begin
            d.rdata = {1'b1, q.evq[0].level, q.evq[0].source, q.evq[0].stamp[25:0]};
            for (int i = 0; i < EQ - 1; i++) begin
              d.evq[i] = d.evq[i + 1];
            end
            d.evn = d.evn - 3'h1;
          end
        end
        default: begin
          if (i_avs_address >= ADDR_CNT0 &&
              32'(i_avs_address - ADDR_CNT0) < NUM_CNT) begin
            d.rdata = q.cnt[3'(i_avs_address - ADDR_CNT0)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      q        <= '0;
      q.st     <= ST_READY;
      q.ctrl   <= CTRL_RESET;
      q.evt_en <= EVT_EN_RESET;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !q.ack;
  assign o_avs_readdata    = q.rdata;
  assign o_open_request    = (q.st == ST_OPENING);
  assign o_close_request   = (q.st == ST_CLOSING);
  assign o_request_on      = q.cause;
  assign o_ready           = (q.st == ST_READY) && en_eff;
  assign o_running         = in_seq;
  assign o_dead_time       = (q.st == ST_DEAD);
  assign o_reclaim_time    = (q.st == ST_RECLAIM);
  assign o_locked          = (q.st == ST_LOCKED);
  assign o_recloser_on     = en_eff;
  assign o_irq             = |(q.irq_st & q.irq_msk);
endmodule // arc_io
`default_nettype wire

// ==== shared/arc_pkg.sv ====
`default_nettype none
package arc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_EVT_EN  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h4;
  localparam logic [3:0] ADDR_EVT_POP = 4'h5;
  localparam logic [3:0] ADDR_CNT_CLR = 4'h6;
  localparam logic [3:0] ADDR_CNT0    = 4'h8;
  localparam int         NUM_CNT      = 7;
  localparam int         CNT_SHOT     = 5;
  localparam int         CNT_CRIT     = 6;
  localparam int         NUM_IN       = 10;
  localparam int         NUM_EVT_SRC  = 14;
  localparam int         IRQ_BITS     = 4;
  localparam int         IRQ_EVENT    = 0;
  localparam int         IRQ_LOCK     = 1;
  localparam int         IRQ_FAIL     = 2;
  localparam int         IRQ_SHOT     = 3;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [31:0] EVT_EN_RESET = 32'h0000_3FFF;
  localparam int         CTRL_ENABLE  = 0;
  localparam int         CTRL_SELECT  = 1;
  localparam int         CTRL_REL     = 2;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ     = 100_000_000;
  localparam int TICK_MS    = 1;
  localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_READY, ST_OPENING, ST_DEAD, ST_CLOSING,
                            ST_RECLAIM, ST_LOCKED} arc_state_t;
  typedef struct packed {
    logic [4:0] reclose_request;
    logic       recloser_enable_input;
    logic       lock_release_input;
    logic       lock_force_input;
    logic       immediate_lock_request;
    logic       fault_present;
  } arc_in_t;
  typedef struct packed {
    logic open_done;
    logic close_done;
    logic check_failed;
    logic manual_open;
    logic manual_close;
    logic dead_expired;
    logic reclaim_expired;
  } arc_obj_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [3:0]  source;
    logic        level;
  } arc_event_t;
endpackage
`default_nettype wire

// ==== verification/arc_io_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module arc_io_assertions
  import arc_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_reset,
  input wire arc_in_t    i_inputs,
  input wire arc_obj_t   i_object,
  input wire logic       o_open_request,
  input wire logic       o_close_request,
  input wire logic [4:0] o_request_on,
  input wire logic       o_ready,
  input wire logic       o_dead_time,
  input wire logic       o_reclaim_time,
  input wire logic       o_locked
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_cmd; !(o_open_request && o_close_request); endproperty
  a_cmd: assert property (p_cmd) else $error("open and close together");
  property p_cause; $onehot0(o_request_on); endproperty
  a_cause: assert property (p_cause) else $error("cause not one-hot");
  property p_crit; $rose(i_inputs.immediate_lock_request) |-> ##[1:6] o_locked; endproperty
  a_crit: assert property (p_crit) else $error("no lock on critical");
  property p_force; i_inputs.lock_force_input [*5] |-> o_locked && !o_ready; endproperty
  a_force: assert property (p_force) else $error("lock force ignored");
  property p_fail;
    i_object.check_failed && (o_open_request || o_close_request) |=> o_locked;
  endproperty
  a_fail: assert property (p_fail) else $error("no lock on check failure");
  property p_man; o_dead_time && i_object.manual_open |=> !o_dead_time; endproperty
  a_man: assert property (p_man) else $error("manual open kept sequence");
  property p_recl;
    i_inputs.fault_present [*4] ##0 (o_dead_time && i_object.manual_close) |=> o_reclaim_time;
  endproperty
  a_recl: assert property (p_recl) else $error("manual close skipped reclaim");
  property p_close; $rose(o_close_request) |-> $past(o_dead_time); endproperty
  a_close: assert property (p_close) else $error("close outside dead end");
  property p_shot; $rose(o_open_request) |-> $past(o_ready || o_reclaim_time); endproperty
  a_shot: assert property (p_shot) else $error("open from wrong state");
endmodule // arc_io_assertions
bind arc_io arc_io_assertions arc_io_assertions_inst (
  .i_clock, .i_reset, .i_inputs, .i_object, .o_open_request, .o_close_request,
  .o_request_on, .o_ready, .o_dead_time, .o_reclaim_time, .o_locked
);
`default_nettype wire

// ==== verification/arc_obj_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module arc_obj_model
  import arc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_open,
  input  wire logic       i_close,
  input  wire logic       i_dead,
  input  wire logic       i_reclaim,
  input  wire logic       i_fail,
  input  wire logic       i_man_open,
  input  wire logic       i_man_close,
  input  wire logic [3:0] i_delay,
  output arc_obj_t        o_obj
);
  logic [3:0] cnt_q;
  logic [4:0] hit_q;
  // A phase entered from idle is answered i_delay+1 cycles after it starts; a commanded failure replaces the open or close done
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= '0;
      hit_q <= '0;
    end else begin
      hit_q <= '0;
      if (!(i_open || i_close || i_dead || i_reclaim)) cnt_q <= '0;
      else if (cnt_q == i_delay) begin
        cnt_q <= '0;
        hit_q <= {i_open && !i_fail, i_close && !i_fail, i_fail && (i_open || i_close),
                  i_dead, i_reclaim};
      end else cnt_q <= cnt_q + 4'h1;
    end
  end
  assign o_obj = {hit_q[4:2], i_man_open, i_man_close, hit_q[1:0]};
endmodule // arc_obj_model
`default_nettype wire

// ==== verification/tb_arc_io.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_arc_io;
  import arc_pkg::*;
  logic        i_clock, i_reset, rd, wr, wreq, m_o, m_c, fail;
  logic        op, cl, rdy, run, dead, recl, lck, on, irq;
  logic [3:0]  addr, dly;
  logic [4:0]  ron, st;
  logic [31:0] wdata, rdata, r, s;
  arc_in_t     inp;
  arc_obj_t    obj;
  int          n_mismatch, check_count;
  assign st = {lck, recl, rdy, dead, op};
  arc_io #(.TICK_CYCLES(10)) arc_io_inst (.i_clock, .i_reset, .i_inputs(inp), .i_object(obj),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_open_request(op),
    .o_close_request(cl), .o_request_on(ron), .o_ready(rdy), .o_running(run),
    .o_dead_time(dead), .o_reclaim_time(recl), .o_locked(lck), .o_recloser_on(on), .o_irq(irq));
  arc_obj_model arc_obj_model_inst (.i_clock, .i_reset, .i_open(op), .i_close(cl),
    .i_dead(dead), .i_reclaim(recl), .i_fail(fail), .i_man_open(m_o), .i_man_close(m_c),
    .i_delay(dly), .o_obj(obj));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clock iff wreq === 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge i_clock);
      if (st[k] === 1'b1) break;
    end
    chk("wait", 1, n < 400);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic rel;
    inp.lock_release_input <= 1'b1;
    cyc(6);
    inp.lock_release_input <= 1'b0;
    cyc(6);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    i_reset = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = '0;
    m_o = 1'b0;
    m_c = 1'b0;
    fail = 1'b0;
    dly = 4'h3;
    inp = '0;
    inp.recloser_enable_input = 1'b1;
    cyc(16);
    i_reset <= 1'b0;
    cyc(8);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl", CTRL_RESET, r);
    bus(0, ADDR_EVT_EN, 0);
    chk("evt_en", EVT_EN_RESET, r);
    bus(0, ADDR_STATUS, 0);
    chk("status", 32'h0000_0400, r);
    bus(0, 4'h7, 0);
    chk("unmapped", 0, r);
    inp.reclose_request <= 5'h14;
    wt(0);
    chk("cause", 5'h04, ron);
    wt(1);
    chk("running", 1, run);
    inp.reclose_request <= 5'h00;
    wt(2);
    bus(0, ADDR_CNT0 + 4'h2, 0);
    chk("reclose_request_3 count", 1, r);
    bus(0, ADDR_CNT0 + 4'h4, 0);
    chk("reclose_request_5 count", 0, r);
    bus(0, ADDR_CNT0 + 4'h5, 0);
    chk("shot count", 1, r);
    bus(0, ADDR_IRQ_ST, 0);
    chk("shot flag", 1, r[IRQ_SHOT]);
    chk("irq masked", 0, irq);
    bus(1, ADDR_IRQ_MSK, 32'h0000_0008);
    chk("irq on", 1, irq);
    bus(1, ADDR_IRQ_ST, 32'h0000_000F);
    chk("irq off", 0, irq);
    bus(1, ADDR_CNT_CLR, 32'h0000_0024);
    bus(0, ADDR_CNT0 + 4'h2, 0);
    chk("clr", 0, r);
    repeat (6) bus(0, ADDR_EVT_POP, 0);
    bus(1, ADDR_EVT_EN, 32'h0000_0100);
    inp.recloser_enable_input <= 1'b0;
    cyc(30);
    inp.recloser_enable_input <= 1'b1;
    chk("select off", 1, on);
    cyc(5);
    bus(0, ADDR_EVT_POP, 0);
    s = r;
    chk("evt fall", 6'h28, r[31:26]);
    bus(0, ADDR_EVT_POP, 0);
    chk("evt rise", 6'h38, r[31:26]);
    chk("stamp", 3, r[25:0] - s[25:0]);
    bus(1, ADDR_CTRL, 32'h0000_0003);
    inp.recloser_enable_input <= 1'b0;
    cyc(6);
    chk("select on", 0, on);
    inp.recloser_enable_input <= 1'b1;
    bus(1, ADDR_CTRL, 32'h0000_0001);
    inp.lock_force_input <= 1'b1;
    cyc(6);
    chk("forced", 1, lck);
    inp.lock_force_input <= 1'b0;
    cyc(6);
    chk("held", 0, rdy);
    rel;
    chk("released", 1, rdy);
    inp.immediate_lock_request <= 1'b1;
    cyc(6);
    chk("crit", 1, lck);
    chk("no shot", 0, op);
    inp.immediate_lock_request <= 1'b0;
    bus(0, ADDR_CNT0 + 4'h6, 0);
    chk("crit count", 1, r);
    bus(1, ADDR_CTRL, 32'h0000_0005);
    cyc(3);
    chk("sw release", 1, rdy);
    fail <= 1'b1;
    inp.reclose_request <= 5'h01;
    wt(4);
    fail <= 1'b0;
    inp.reclose_request <= 5'h00;
    rel;
    dly <= 4'hF;
    inp.reclose_request <= 5'h02;
    wt(1);
    inp.reclose_request <= 5'h00;
    m_o <= 1'b1;
    cyc(1);
    m_o <= 1'b0;
    cyc(3);
    chk("man open", 0, dead);
    wt(2);
    inp.fault_present <= 1'b1;
    inp.reclose_request <= 5'h01;
    wt(1);
    inp.reclose_request <= 5'h00;
    m_c <= 1'b1;
    cyc(1);
    m_c <= 1'b0;
    wt(3);
    wt(4);
    inp.fault_present <= 1'b0;
    rel;
    chk("final", 1, rdy);
    print_verdict;
  end
endmodule // tb_arc_io
`default_nettype wire
